// File: logic/csfc_defs.svh
// constants for the clock switch and fail control block
`ifndef CSFC_DEFS_SVH
`define CSFC_DEFS_SVH
// word addresses on the register bus
`define CSFC_ADDR_OSC      3'h0
`define CSFC_ADDR_KEY      3'h1
`define CSFC_ADDR_STAT     3'h2
`define CSFC_ADDR_MASK     3'h3
`define CSFC_ADDR_CFG      3'h4
// oscillator_control fields
`define CSFC_BIT_SWREQ     0
`define CSFC_BIT_CFAIL     3
`define CSFC_NSRC_LSB      8
`define CSFC_NSRC_MSB      10
`define CSFC_CSRC_LSB      12
`define CSFC_CSRC_MSB      14
// configuration readback fields
`define CSFC_CFG_INIT_LSB  0
`define CSFC_CFG_INIT_MSB  2
`define CSFC_CFG_MODE_LSB  4
`define CSFC_CFG_MODE_MSB  5
// interrupt status and mask bits
`define CSFC_IRQ_W         3
`define CSFC_IRQ_DONE      0
`define CSFC_IRQ_FAIL      1
`define CSFC_IRQ_REJ       2
// switch_monitor_mode decoding
`define CSFC_MODE_DIS_BIT  1
`define CSFC_MODE_SW_FS    2'h0
// source codes that matter to the switch check
`define CSFC_SRC_FAST_RC_WITH_PLL    3'h1
`define CSFC_SRC_PRIPLL    3'h3
// unlock keys
`define CSFC_KEY1          16'h0055
`define CSFC_KEY2          16'h00aa
// reset values
`define CSFC_RST_SRC       3'h0
`define CSFC_RST_MODE      2'h3
`define CSFC_RST_WORD      32'h0000_0000
`define CSFC_RST_IRQ       3'h0
`endif

// File: logic/csfc_pkg.sv
// types and helpers for the clock switch and fail control block
`default_nettype none
`include "csfc_defs.svh"
package csfc_pkg;
   typedef enum logic [2:0] {
      CSFC_UL_IDLE = 3'b001,
      CSFC_UL_KEY1 = 3'b010,
      CSFC_UL_OPEN = 3'b100
   } csfc_ul_t;

   typedef enum logic [2:0] {
      CSFC_FRC       = 3'b000,
      CSFC_FRC_PLL   = 3'b001,
      CSFC_PRI       = 3'b010,
      CSFC_PRI_PLL   = 3'b011,
      CSFC_RSVD      = 3'b100,
      CSFC_LOW_POWER_RC_OSCILLATOR      = 3'b101,
      CSFC_FRC_DIV16 = 3'b110,
      CSFC_FRC_POST  = 3'b111
   } csfc_src_t;

   // direct hops between the two pll sources are refused
   function automatic logic csfc_forbidden(input logic [2:0] cur,
                                           input logic [2:0] tgt);
      csfc_forbidden = (cur == `CSFC_SRC_FAST_RC_WITH_PLL && tgt == `CSFC_SRC_PRIPLL) ||
                       (cur == `CSFC_SRC_PRIPLL && tgt == `CSFC_SRC_FAST_RC_WITH_PLL);
   endfunction

   // byte-enable merge on a 16-bit word
   function automatic logic [15:0] csfc_merge(input logic [15:0] old,
                                              input logic [15:0] nw,
                                              input logic [1:0]  be);
      csfc_merge = {be[1] ? nw[15:8] : old[15:8],
                    be[0] ? nw[7:0]  : old[7:0]};
   endfunction
endpackage
`default_nettype wire

// File: logic/csfc_unlock.sv
// unlock sequence tracker guarding oscillator_control writes
`timescale 1ns/1ps
`default_nettype none
`include "csfc_defs.svh"
module csfc_unlock
   import csfc_pkg::*;
#(
   parameter logic [15:0] KEY1 = `CSFC_KEY1,
   parameter logic [15:0] KEY2 = `CSFC_KEY2
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_acc,
   input  wire logic        i_key_wr,
   input  wire logic [15:0] i_key_data,
   output logic             o_unlocked
);
   csfc_ul_t state_q;
   csfc_ul_t state_d;

   // any access other than the next key step closes the lock again
   always_comb begin
      state_d = state_q;
      if (i_acc) begin
         if (i_key_wr && i_key_data == KEY1) begin
            state_d = CSFC_UL_KEY1;
         end else if (i_key_wr && state_q == CSFC_UL_KEY1 &&
                      i_key_data == KEY2) begin
            state_d = CSFC_UL_OPEN;
         end else begin
            state_d = CSFC_UL_IDLE;
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state_q <= CSFC_UL_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_unlocked = (state_q == CSFC_UL_OPEN);
endmodule // csfc_unlock
`default_nettype wire

// File: logic/csfc_top.sv
// clock switch request and clock fail status with avalon register access
`timescale 1ns/1ps
`default_nettype none
`include "csfc_defs.svh"
module csfc_top
   import csfc_pkg::*;
#(
   parameter logic [15:0] KEY1 = `CSFC_KEY1,
   parameter logic [15:0] KEY2 = `CSFC_KEY2
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst,
   input  wire logic        i_warm_rst,
   input  wire logic [2:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic             o_avs_waitrequest,
   output logic [31:0]      o_avs_readdata,
   input  wire logic [1:0]  i_switch_monitor_mode,
   input  wire logic [2:0]  i_initial_source_select,
   input  wire logic        i_clock_fail,
   input  wire logic        i_switch_done,
   output logic             o_switch_req,
   output logic [2:0]       o_switch_target,
   output logic [2:0]       o_current_source,
   output logic             o_fail_monitor_enable,
   output logic             o_clock_fail,
   output logic             o_irq
);
   // bus state, cleared by either reset
   logic                    wait_q, wait_d;
   logic [31:0]             rdata_q, rdata_d;
   logic [`CSFC_IRQ_W-1:0]  stat_q, stat_d, mask_q, mask_d;
   logic                    irq_q, irq_d;
   // oscillator state, cleared by power-on reset only
   logic                    captured_q, captured_d;
   logic [1:0]              mode_q, mode_d;
   logic [2:0]              init_q, init_d;
   logic [2:0]              cur_q, cur_d, new_q, new_d;
   logic                    sw_req_q, sw_req_d, cf_q, cf_d;
   logic                    fs_en_q, fs_en_d;

   logic                    acc, wr_acc, ctrl_wr, unlocked, bus_rst;
   logic                    sw_en, fail_ev, done_ev, rej_ev;
   logic [15:0]             osc_word, wdata;
   logic [`CSFC_IRQ_W-1:0]  events;

   assign bus_rst = i_rst | i_warm_rst;
   assign acc     = (i_avs_read | i_avs_write) & ~wait_q;
   assign wr_acc  = i_avs_write & ~wait_q;

   csfc_unlock #(
      .KEY1 (KEY1),
      .KEY2 (KEY2)
   ) u_unlock (
      .i_core_clk (i_core_clk),
      .i_rst      (bus_rst),
      .i_acc      (acc),
      .i_key_wr   (wr_acc && i_avs_address == `CSFC_ADDR_KEY),
      .i_key_data (i_avs_writedata[15:0]),
      .o_unlocked (unlocked)
   );

   always_comb begin
      osc_word = 16'h0000;
      osc_word[`CSFC_CSRC_MSB:`CSFC_CSRC_LSB] = cur_q;
      osc_word[`CSFC_NSRC_MSB:`CSFC_NSRC_LSB] = new_q;
      osc_word[`CSFC_BIT_CFAIL] = cf_q;
      osc_word[`CSFC_BIT_SWREQ] = sw_req_q;
   end

   assign wdata = csfc_merge(osc_word, i_avs_writedata[15:0],
                             i_avs_byteenable[1:0]);
   assign ctrl_wr = wr_acc && i_avs_address == `CSFC_ADDR_OSC && unlocked;
   assign sw_en   = ~mode_q[`CSFC_MODE_DIS_BIT];
   assign fail_ev = i_clock_fail & fs_en_q & captured_q;

   // oscillator control next state
   always_comb begin
      captured_d = 1'b1;
      mode_d     = mode_q;
      init_d     = init_q;
      cur_d      = cur_q;
      new_d      = new_q;
      sw_req_d   = sw_req_q;
      cf_d       = cf_q;
      done_ev    = 1'b0;
      rej_ev     = 1'b0;
      if (!captured_q) begin
         mode_d = i_switch_monitor_mode;
         init_d = i_initial_source_select;
         cur_d  = i_initial_source_select;
         new_d  = i_initial_source_select;
      end else begin
         if (ctrl_wr) begin
            if (!sw_req_q) begin
               new_d = wdata[`CSFC_NSRC_MSB:`CSFC_NSRC_LSB];
            end
            // software clears the flag by writing zero
            if (!wdata[`CSFC_BIT_CFAIL]) begin
               cf_d = 1'b0;
            end
            if (wdata[`CSFC_BIT_SWREQ] && sw_en && !sw_req_q) begin
               if (csfc_forbidden(cur_q,
                                  wdata[`CSFC_NSRC_MSB:`CSFC_NSRC_LSB])) begin
                  rej_ev = 1'b1;
               end else begin
                  sw_req_d = 1'b1;
               end
            end
         end
         if (sw_req_q && i_switch_done) begin
            cur_d    = new_q;
            sw_req_d = 1'b0;
            done_ev  = 1'b1;
         end
         if (fail_ev) begin
            cf_d = 1'b1;
         end
      end
      fs_en_d = (mode_d == `CSFC_MODE_SW_FS);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         captured_q <= 1'b0;
         mode_q     <= `CSFC_RST_MODE;
         init_q     <= `CSFC_RST_SRC;
         cur_q      <= `CSFC_RST_SRC;
         new_q      <= `CSFC_RST_SRC;
         sw_req_q   <= 1'b0;
         cf_q       <= 1'b0;
         fs_en_q    <= 1'b0;
      end else begin
         captured_q <= captured_d;
         mode_q     <= mode_d;
         init_q     <= init_d;
         cur_q      <= cur_d;
         new_q      <= new_d;
         sw_req_q   <= sw_req_d;
         cf_q       <= cf_d;
         fs_en_q    <= fs_en_d;
      end
   end

   always_comb begin
      events = '0;
      events[`CSFC_IRQ_DONE] = done_ev;
      events[`CSFC_IRQ_FAIL] = fail_ev;
      events[`CSFC_IRQ_REJ]  = rej_ev;
   end

   // bus, status and mask next state
   always_comb begin
      wait_d  = ~((i_avs_read | i_avs_write) & wait_q);
      rdata_d = rdata_q;
      stat_d  = stat_q;
      mask_d  = mask_q;
      if (i_avs_read && wait_q) begin
         rdata_d = `CSFC_RST_WORD;
         unique case (i_avs_address)
            `CSFC_ADDR_OSC:  rdata_d[15:0] = osc_word;
            `CSFC_ADDR_STAT: rdata_d[`CSFC_IRQ_W-1:0] = stat_q;
            `CSFC_ADDR_MASK: rdata_d[`CSFC_IRQ_W-1:0] = mask_q;
            `CSFC_ADDR_CFG: begin
               rdata_d[`CSFC_CFG_INIT_MSB:`CSFC_CFG_INIT_LSB] = init_q;
               rdata_d[`CSFC_CFG_MODE_MSB:`CSFC_CFG_MODE_LSB] = mode_q;
            end
            default: rdata_d = `CSFC_RST_WORD;
         endcase
      end
      if (wr_acc && i_avs_byteenable[0]) begin
         if (i_avs_address == `CSFC_ADDR_STAT) begin
            stat_d = stat_q & ~i_avs_writedata[`CSFC_IRQ_W-1:0];
         end
         if (i_avs_address == `CSFC_ADDR_MASK) begin
            mask_d = i_avs_writedata[`CSFC_IRQ_W-1:0];
         end
      end
      // a new event wins over a same-cycle clear
      stat_d = stat_d | events;
      irq_d  = |(stat_q & mask_q);
   end

   always_ff @(posedge i_core_clk) begin
      if (bus_rst) begin
         wait_q  <= 1'b1;
         rdata_q <= `CSFC_RST_WORD;
         stat_q  <= `CSFC_RST_IRQ;
         mask_q  <= `CSFC_RST_IRQ;
         irq_q   <= 1'b0;
      end else begin
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
         stat_q  <= stat_d;
         mask_q  <= mask_d;
         irq_q   <= irq_d;
      end
   end

   assign o_avs_waitrequest     = wait_q;
   assign o_avs_readdata        = rdata_q;
   assign o_switch_req          = sw_req_q;
   assign o_switch_target       = new_q;
   assign o_current_source      = cur_q;
   assign o_fail_monitor_enable = fs_en_q;
   assign o_clock_fail          = cf_q;
   assign o_irq                 = irq_q;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   AST_CF_SET: assert property (fail_ev |=> cf_q)
      else $error("clock fail event did not set the flag");
   AST_CF_STICKY: assert property (
      cf_q && !ctrl_wr |=> cf_q)
      else $error("clock fail flag dropped without a clearing write");
   AST_REQ_DONE: assert property (
      sw_req_q && i_switch_done |=> !sw_req_q && cur_q == $past(new_q))
      else $error("switch request not cleared on completion");
   AST_REQ_HOLD: assert property (
      sw_req_q && !i_switch_done |=> sw_req_q)
      else $error("switch request dropped before completion");
   AST_UNLOCK_SEQ: assert property (
      $past(captured_q) && new_q != $past(new_q) |-> $past(unlocked))
      else $error("new source changed without unlock");
   AST_LOCKED_IGNORE: assert property (
      captured_q && wr_acc && i_avs_address == `CSFC_ADDR_OSC && !unlocked
      |=> $stable(new_q) && !$rose(sw_req_q))
      else $error("locked write altered oscillator control");
   AST_WARM_KEEP: assert property (
      captured_q && i_warm_rst |=> $stable(new_q) && $stable(cur_q))
      else $error("warm reset disturbed oscillator control");
   AST_MODE_GATE: assert property (
      captured_q && mode_q[`CSFC_MODE_DIS_BIT] |-> !sw_req_q && !fs_en_q)
      else $error("switching or monitor active while disabled");
   AST_INIT_SRC: assert property (
      $rose(captured_q) |-> cur_q == init_q && new_q == init_q)
      else $error("start-up source not taken from configuration");

   COV_SWITCH: cover property (sw_req_q ##[1:20] !sw_req_q);
   COV_FAIL:   cover property (fail_ev ##1 cf_q);
   COV_REJ:    cover property (rej_ev);
endmodule // csfc_top
`default_nettype wire

// File: verif/csfc_osc_model.sv
// stand-in for the clock mux and the fail-safe monitor
`timescale 1ns/1ps
`default_nettype none
module csfc_osc_model (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst,
   input  wire logic       i_switch_req,
   input  wire logic [3:0] i_delay,
   input  wire logic       i_inject_fail,
   output logic            o_switch_done,
   output logic            o_clock_fail
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       done_d;

   // one-cycle done after a settle time
   always_comb begin
      cnt_d  = 4'h0;
      done_d = 1'b0;
      if (i_switch_req && !o_switch_done) begin
         cnt_d  = cnt_q + 4'h1;
         done_d = (cnt_q == i_delay);
      end
   end

   // monitor reports failure whatever the mode; the block must gate it
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         cnt_q         <= 4'h0;
         o_switch_done <= 1'b0;
         o_clock_fail  <= 1'b0;
      end else begin
         cnt_q         <= cnt_d;
         o_switch_done <= done_d;
         o_clock_fail  <= i_inject_fail;
      end
   end
endmodule // csfc_osc_model
`default_nettype wire

// File: verif/clock_switch_fail_control_tb_top.sv
// self-checking bench for the clock switch and fail block
`timescale 1ns/1ps
`default_nettype none
`include "csfc_defs.svh"
module clock_switch_fail_control_tb_top import csfc_pkg::*;;
   logic        clk;
   logic        rst;
   logic        warm;
   logic [2:0]  adr;
   logic        rd;
   logic        wr;
   logic [31:0] wd;
   logic        wreq;
   logic [31:0] rdat;
   logic [1:0]  mode;
   logic [2:0]  init;
   logic        fail;
   logic        done;
   logic        swreq;
   logic [2:0]  tgt;
   logic [2:0]  cur;
   logic        fen;
   logic        cflag;
   logic        irq;
   logic        inj;
   logic [3:0]  dly;
   logic [31:0] q;
   int          error_cnt;
   int          checked;
   int          cyc;

   csfc_top u_dut (.i_core_clk(clk), .i_rst(rst), .i_warm_rst(warm),
      .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(4'h3),
      .o_avs_waitrequest(wreq), .o_avs_readdata(rdat),
      .i_switch_monitor_mode(mode), .i_initial_source_select(init),
      .i_clock_fail(fail), .i_switch_done(done), .o_switch_req(swreq),
      .o_switch_target(tgt), .o_current_source(cur),
      .o_fail_monitor_enable(fen), .o_clock_fail(cflag), .o_irq(irq));

   csfc_osc_model u_osc (.i_core_clk(clk), .i_rst(rst),
      .i_switch_req(swreq), .i_delay(dly), .i_inject_fail(inj),
      .o_switch_done(done), .o_clock_fail(fail));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end

   task automatic final_report;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [2:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      wr  <= w;
      rd  <= !w;
      adr <= a;
      wd  <= d;
      do @(posedge clk); while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask

   // key pair then the control write as three accesses with no other access between
   task automatic unl_wr(input logic [31:0] d);
      bus(1'b1, `CSFC_ADDR_KEY, {16'h0, `CSFC_KEY1});
      bus(1'b1, `CSFC_ADDR_KEY, {16'h0, `CSFC_KEY2});
      bus(1'b1, `CSFC_ADDR_OSC, d);
   endtask

   function automatic logic [31:0] osc_w(input logic [2:0] c,
      input logic [2:0] t, input logic f, input logic r);
      osc_w = {17'h0, c, 1'b0, t, 4'h0, f, 2'h0, r};
   endfunction

   task automatic wait_sw;
      while (swreq !== 1'b1) @(posedge clk);
      while (swreq !== 1'b0) @(posedge clk);
   endtask

   task automatic por(input logic [1:0] m, input logic [2:0] s);
      mode <= m;
      init <= s;
      rst  <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic t_start;
      rd_chk(`CSFC_ADDR_OSC, osc_w(3'h1, 3'h1, 1'b0, 1'b0));
      rd_chk(`CSFC_ADDR_CFG, 32'h01);
      rd_chk(3'h7, 32'h0);
      chk(fen, 1'b1);
   endtask

   // writes without a full key pair leave the register alone
   task automatic t_locked;
      bus(1'b1, `CSFC_ADDR_OSC, 32'h0001);
      bus(1'b1, `CSFC_ADDR_KEY, {16'h0, `CSFC_KEY1});
      bus(1'b1, `CSFC_ADDR_OSC, 32'h0001);
      rd_chk(`CSFC_ADDR_OSC, osc_w(3'h1, 3'h1, 1'b0, 1'b0));
      chk(swreq, 1'b0);
   endtask

   // direct pll to pll hop is refused and flagged
   task automatic t_forbid;
      bus(1'b1, `CSFC_ADDR_MASK, 32'h6);
      unl_wr(32'h0301);
      repeat (3) @(posedge clk);
      chk(swreq, 1'b0);
      chk(irq, 1'b1);
      rd_chk(`CSFC_ADDR_STAT, 32'h4);
      bus(1'b1, `CSFC_ADDR_STAT, 32'h4);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
   endtask

   // hop through fast rc, fast then slow mux
   task automatic t_hop;
      dly <= 4'h0;
      unl_wr(32'h0001);
      wait_sw();
      rd_chk(`CSFC_ADDR_OSC, osc_w(3'h0, 3'h0, 1'b0, 1'b0));
      dly <= 4'h5;
      unl_wr(32'h0301);
      repeat (2) @(posedge clk);
      chk({swreq, tgt}, 4'hb);
      wait_sw();
      chk(cur, 3'h3);
      rd_chk(`CSFC_ADDR_STAT, 32'h1);
      chk(irq, 1'b0);
      bus(1'b1, `CSFC_ADDR_STAT, 32'h1);
   endtask

   // sticky flag survives status clear, cleared by software
   task automatic t_fail;
      inj <= 1'b1;
      @(posedge clk);
      inj <= 1'b0;
      repeat (3) @(posedge clk);
      chk({cflag, irq}, 2'h3);
      rd_chk(`CSFC_ADDR_OSC, osc_w(3'h3, 3'h3, 1'b1, 1'b0));
      bus(1'b1, `CSFC_ADDR_STAT, 32'h2);
      repeat (2) @(posedge clk);
      chk({cflag, irq}, 2'h2);
      unl_wr(32'h0300);
      rd_chk(`CSFC_ADDR_OSC, osc_w(3'h3, 3'h3, 1'b0, 1'b0));
   endtask

   // warm reset keeps control, clears mask; disabled mode
   task automatic t_resets;
      warm <= 1'b1;
      repeat (2) @(posedge clk);
      warm <= 1'b0;
      rd_chk(`CSFC_ADDR_OSC, osc_w(3'h3, 3'h3, 1'b0, 1'b0));
      rd_chk(`CSFC_ADDR_MASK, 32'h0);
      por(2'h2, 3'h5);
      chk({fen, cur}, 4'h5);
      rd_chk(`CSFC_ADDR_CFG, 32'h25);
      inj <= 1'b1;
      unl_wr(32'h0001);
      inj <= 1'b0;
      repeat (4) @(posedge clk);
      chk({swreq, cflag}, 2'h0);
   endtask

   // switching enabled with the monitor off
   task automatic t_swonly;
      por(2'h1, 3'h0);
      chk({fen, cur}, 4'h0);
      inj <= 1'b1;
      repeat (3) @(posedge clk);
      inj <= 1'b0;
      unl_wr(32'h0101);
      wait_sw();
      chk({cur, cflag}, 4'h2);
   endtask

   initial begin
      rst = 1'b1;
      warm = 1'b0;
      adr = 3'h0;
      rd = 1'b0;
      wr = 1'b0;
      wd = 32'h0;
      mode = 2'h0;
      init = 3'h1;
      inj = 1'b0;
      dly = 4'h0;
      por(2'h0, 3'h1);
      t_start();
      t_locked();
      t_forbid();
      t_hop();
      t_fail();
      t_resets();
      t_swonly();
      final_report();
   end
endmodule // clock_switch_fail_control_tb_top
`default_nettype wire
